/* File: rxie_map.vh */
// Register map, field positions and reset values of the receive-mode
// interrupt status and enable block.
// Assumes byte addressing on a 16-bit register port with 32-bit data.
`ifndef RXIE_MAP_VH
`define RXIE_MAP_VH

// Register byte offsets
`define RXIE_OFF_FLAGS      16'h0030
`define RXIE_OFF_MASK       16'h0034
`define RXIE_OFF_CMD        16'h004E

// Widths
`define RXIE_ADDR_W         16
`define RXIE_DATA_W         32
`define RXIE_CMD_W          16

// Status bits that exist; bits 27, 24 and 23 are reserved
`define RXIE_FLAG_VALID     32'hF67FFFFF
// Status bits that follow a level instead of latching an event
`define RXIE_FLAG_LEVEL     32'h00004000
// Status reset value
`define RXIE_FLAG_RESET     32'h00000000

// Enable reset value and the bits software may write
`define RXIE_MASK_RESET     32'hF67FFFFF
`define RXIE_MASK_WRITE     32'hF673FFFF

// Command bits software may set; the chip clears them when done
`define RXIE_CMD_WRITE      16'h83B0
`define RXIE_CMD_RESET      16'h0000

// Command bit positions
`define RXIE_CMD_CLEAR_IRQ  5
`define RXIE_CMD_FAST_CHG   7

// Status bit positions
`define RXIE_BIT_OVER_CUR   0
`define RXIE_BIT_OVER_VOLT  1
`define RXIE_BIT_OVER_TEMP  2
`define RXIE_BIT_FAST_OK    3
`define RXIE_BIT_PROP_PKT   4
`define RXIE_BIT_MODE_CHG   5
`define RXIE_BIT_REG_ON     6
`define RXIE_BIT_REG_OFF    7
`define RXIE_BIT_DEV_FAIL   8
`define RXIE_BIT_DEV_PASS   9
`define RXIE_BIT_BC_TMO     10
`define RXIE_BIT_BC_ACK     11
`define RXIE_BIT_ID_FAIL    12
`define RXIE_BIT_ID_PASS    13
`define RXIE_BIT_SLEEP      14
`define RXIE_BIT_FAST_FAIL  15

`endif

/* File: rxie_flag_bank.v */
// Bank of interrupt status flags, one per source bit.
// Assumes event and level inputs come from logic on the same clock.
`timescale 1ns/10ps
`include "rxie_map.vh"

module rxie_flag_bank (
	input  wire        clk,
	input  wire        arst_n,
	input  wire [31:0] setEvt,
	input  wire [31:0] levelIn,
	input  wire        clrAll,
	output wire [31:0] flags
);

	localparam [31:0] VALID = `RXIE_FLAG_VALID;
	localparam [31:0] LEVEL = `RXIE_FLAG_LEVEL;
	localparam [31:0] RSTV  = `RXIE_FLAG_RESET;

	genvar i;
	generate
		for (i = 0; i < 32; i = i + 1) begin : gFlag
			if (!VALID[i]) begin : gRsvd
				// Reserved bits read zero
				assign flags[i] = 1'b0;
			end else if (LEVEL[i]) begin : gLevel
				reg bitQ;
				// Level bits show the condition as it stands
				always @(posedge clk or negedge arst_n) begin
					if (!arst_n)
						bitQ <= RSTV[i];
					else
						bitQ <= levelIn[i];
				end
				assign flags[i] = bitQ;
			end else begin : gSticky
				reg bitQ;
				// Event bits latch; a new event beats a clear
				always @(posedge clk or negedge arst_n) begin
					if (!arst_n)
						bitQ <= RSTV[i];
					else if (setEvt[i])
						bitQ <= 1'b1;
					else if (clrAll)
						bitQ <= 1'b0;
				end
				assign flags[i] = bitQ;
			end
		end
	endgenerate

endmodule

/* File: rxie_cmd_bits.v */
// Self-clearing command bits: software sets, the chip clears when done.
// Assumes write and done strobes are one-cycle pulses on this clock.
`timescale 1ns/10ps
`include "rxie_map.vh"

module rxie_cmd_bits (
	input  wire        clk,
	input  wire        arst_n,
	input  wire        wrEn,
	input  wire [15:0] wrData,
	input  wire [15:0] done,
	output wire [15:0] pending
);

	localparam [15:0] WMASK = `RXIE_CMD_WRITE;
	localparam [15:0] RSTV  = `RXIE_CMD_RESET;

	genvar i;
	generate
		for (i = 0; i < 16; i = i + 1) begin : gCmd
			if (!WMASK[i]) begin : gRsvd
				// Unused command bits read zero
				assign pending[i] = 1'b0;
			end else begin : gBit
				reg bitQ;
				// A fresh request beats completion of the old one
				always @(posedge clk or negedge arst_n) begin
					if (!arst_n)
						bitQ <= RSTV[i];
					else if (wrEn && wrData[i])
						bitQ <= 1'b1;
					else if (done[i])
						bitQ <= 1'b0;
				end
				assign pending[i] = bitQ;
			end
		end
	endgenerate

endmodule

/* File: rxie_rx_interrupt_status_enable.v */
// Receive-mode interrupt status, enable and clear logic with its
// register port and interrupt output.
// Assumes the firmware side runs on clk and drives one-cycle event
// pulses; the register master follows the plain strobe protocol.
//
// What this block does
// - 32-bit enable register at byte offset 0x0034, one mask bit per source.
// - Enable bit at one lets its flag raise the interrupt; resets to one.
// - Enable bit at zero blocks the interrupt; the flag still reports.
// - Status bits 14..0 are read-only, reset to zero, zero when absent.
// - Status bit 14 reads one while the receiver sleeps.
// - Bit 13 sets on identity pass, bit 12 on identity fail.
// - Bit 11 sets when the transmitter acknowledges a back-channel packet.
// - Bit 10 sets when a back-channel packet times out.
// - Bit 9 sets on transmitter authentication pass, bit 8 on fail.
// - Bit 5 on mode change; bits 7 and 6 on regulator off and on.
// - Bit 4 sets when a proprietary packet arrives.
// - Bit 3 sets when the fast-charge voltage switch succeeds.
// - Bit 2 sets on over-temperature.
// - Bit 1 sets on over-voltage.
// - Bit 0 sets on over-current.
// - Status register at 0x0030; upper bits hold the remaining flags.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`include "rxie_map.vh"

module rxie_rx_interrupt_status_enable (
	input  wire        clk,
	input  wire        arst_n,
	// Register port
	input  wire [15:0] regAddr,
	input  wire [31:0] regWData,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [31:0] regRData,
	// Firmware side
	input  wire [31:0] evtSet,
	input  wire        sleepActive,
	input  wire [15:0] fwCmdDone,
	output reg  [15:0] fwCmd,
	output reg         clearBusy,
	// Host interrupt line
	output reg         irqOut
);

	// Clear sequencer states
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_CLR  = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;

	localparam [31:0] MASK_RST = `RXIE_MASK_RESET;
	localparam [31:0] MASK_WR  = `RXIE_MASK_WRITE;
	localparam [31:0] VALID    = `RXIE_FLAG_VALID;

	// Address match, shared by read and write decode
	function hit;
		input [15:0] addr;
		input [15:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	reg  [31:0] enaMask;
	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg  [31:0] next_rdData;
	reg  [31:0] levelVec;
	reg  [15:0] cmdDone;
	wire [31:0] flags;
	wire [31:0] gated;
	wire [15:0] cmdPend;
	wire        wrMask;
	wire        wrCmd;
	wire        rdFlags;
	wire        rdMask;
	wire        rdCmd;
	wire        clrPulse;
	wire        clrReq;

	// Register decode; the status word has no write path, so it stays read-only
	assign wrMask  = regWr && hit(regAddr, `RXIE_OFF_MASK);
	assign wrCmd   = regWr && hit(regAddr, `RXIE_OFF_CMD);
	assign rdFlags = regRd && hit(regAddr, `RXIE_OFF_FLAGS);
	assign rdMask  = regRd && hit(regAddr, `RXIE_OFF_MASK);
	assign rdCmd   = regRd && hit(regAddr, `RXIE_OFF_CMD);

	// Enable register: writable bits follow software, the rest hold
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enaMask <= MASK_RST;
		end else if (wrMask) begin
			enaMask <= (regWData & MASK_WR) | (MASK_RST & ~MASK_WR);
		end
	end

	// Level-following sources; only sleep state is a level
	always @* begin
		levelVec = 32'h00000000;
		levelVec[`RXIE_BIT_SLEEP] = sleepActive;
	end

	// Event flags; a write to the status word is ignored
	rxie_flag_bank uFlags (
		.clk     (clk),
		.arst_n  (arst_n),
		.setEvt  (evtSet),
		.levelIn (levelVec),
		.clrAll  (clrPulse),
		.flags   (flags)
	);

	// Completion of commands: the sequencer finishes the clear,
	// a fast-charge result finishes the fast-charge request, firmware
	// finishes the rest
	always @* begin
		cmdDone = fwCmdDone;
		cmdDone[`RXIE_CMD_CLEAR_IRQ] = (state == ST_DONE);
		cmdDone[`RXIE_CMD_FAST_CHG] = fwCmdDone[`RXIE_CMD_FAST_CHG]
			| evtSet[`RXIE_BIT_FAST_OK] | evtSet[`RXIE_BIT_FAST_FAIL];
	end

	// Command register bits
	rxie_cmd_bits uCmd (
		.clk     (clk),
		.arst_n  (arst_n),
		.wrEn    (wrCmd),
		.wrData  (regWData[15:0]),
		.done    (cmdDone),
		.pending (cmdPend)
	);

	assign clrReq = cmdPend[`RXIE_CMD_CLEAR_IRQ];

	// Clear sequencer: one cycle of clear, then release the command bit
	always @* begin
		case (state)
			ST_IDLE: begin
				if (clrReq)
					next_state = ST_CLR;
				else
					next_state = ST_IDLE;
			end
			ST_CLR: begin
				next_state = ST_DONE;
			end
			ST_DONE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Sequencer state register
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Event flags drop in the clear cycle unless a new event arrives
	assign clrPulse = (state == ST_CLR);

	// Read mux; unmapped addresses and reserved bits read zero
	always @* begin
		next_rdData = 32'h00000000;
		if (rdFlags)
			next_rdData = flags & VALID;
		else if (rdMask)
			next_rdData = enaMask & VALID;
		else if (rdCmd)
			next_rdData = {16'h0000, cmdPend};
	end

	// Read data stand in the cycle after the strobe only
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			regRData <= 32'h00000000;
		else
			regRData <= next_rdData;
	end

	// Enabled flags; a disabled flag still shows in the status word
	assign gated = flags & enaMask;

	// Interrupt output and firmware-facing copies
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irqOut    <= 1'b0;
			fwCmd     <= 16'h0000;
			clearBusy <= 1'b0;
		end else begin
			irqOut    <= |gated;
			fwCmd     <= cmdPend;
			clearBusy <= clrReq;
		end
	end

endmodule

/* File: rxie_dummy_never.v */
// Holds no logic: the block is built from the main module and its two
// helpers, the flag bank and the self-clearing command bits.

/* File: rxie_ise_asserts.sv */
// Port-level assertions for the interrupt status and enable block.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/10ps
module rxie_ise_asserts (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic [15:0] regAddr,
	input wire logic [31:0] regWData,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [31:0] regRData,
	input wire logic [31:0] evtSet,
	input wire logic        sleepActive,
	input wire logic [15:0] fwCmdDone,
	input wire logic [15:0] fwCmd,
	input wire logic        clearBusy,
	input wire logic        irqOut
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Decoded host accesses
	wire rdFlag = regRd && regAddr == 16'h0030;
	wire rdMask = regRd && regAddr == 16'h0034;
	wire wrCmd  = regWr && regAddr == 16'h004E;
	rdata_idle_a: assert property (!regRd |=> regRData == 32'h0)
		else $error("read data not zero without a read");
	mask_fixed_a: assert property (
		rdMask |=> (regRData & 32'h09800000) == 32'h0 && regRData[19:18] == 2'h3)
		else $error("fixed enable bits wrong");
	flag_rsv_a: assert property (rdFlag |=> regRData[27] == 1'b0 && regRData[24:23] == 2'h0)
		else $error("reserved status bits set");
	sleep_flag_a: assert property (rdFlag |=> regRData[14] == $past(sleepActive, 2))
		else $error("sleep flag does not follow sleep level");
	// Event, one idle cycle with no clear edge, then a status read
	evt_flag_a: assert property (
		evtSet[13:0] != 14'h0 ##1 !clearBusy ##1 rdFlag |=>
		(regRData[13:0] & $past(evtSet[13:0], 3)) == $past(evtSet[13:0], 3))
		else $error("event did not set its flag");
	irq_quiet_a: assert property (rdFlag ##1 regRData == 32'h0 |-> !irqOut)
		else $error("interrupt high with no flag set");
	clr_seq_a: assert property (
		wrCmd && regWData[5] |-> ##[1:3] clearBusy ##[1:3] !clearBusy)
		else $error("clear sequence did not run");
	cmd_done_a: assert property (
		fwCmdDone[4] && !(wrCmd && regWData[4]) |-> ##[1:2] !fwCmd[4])
		else $error("command bit not cleared on completion");
	// Main scenarios reached
	cover property ($rose(irqOut));
	cover property ($rose(clearBusy));
	cover property (rdFlag ##1 regRData != 32'h0);
endmodule

/* File: rxie_host_model.sv */
// Host processor model: plain strobe master for the register port.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/10ps
module rxie_host_model (
	input  wire logic        clk,
	output logic      [15:0] regAddr,
	output logic      [31:0] regWData,
	output logic             regWr,
	output logic             regRd,
	input  wire logic [31:0] regRData
);
	// Idle bus at time zero
	initial begin
		regAddr = 16'h0;
		regWData = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
	end
	// One-cycle write; address and data scrambled once released
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		regAddr <= ~a;
		regWData <= ~d;
	endtask
	// One-cycle read; data taken at the edge closing the cycle they stand in
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		regAddr <= ~a;
		@(posedge clk);
		d = regRData;
	endtask
	// Acknowledge pending interrupts through the command register
	task automatic clear_irq;
		wr(16'h004E, 32'h00000020);
		repeat (5) @(posedge clk);
	endtask
endmodule

/* File: rxie_rx_interrupt_status_enable_tb_top.sv */
// Self-checking bench for the interrupt status and enable block.
// Assumes the host model and the port checker are compiled first.
`timescale 1ns/10ps
module rxie_rx_interrupt_status_enable_tb_top;
	logic        clk;
	logic        arst_n;
	logic [15:0] regAddr;
	logic [31:0] regWData;
	logic        regWr;
	logic        regRd;
	logic [31:0] regRData;
	logic [31:0] evtSet;
	logic        sleepActive;
	logic [15:0] fwCmdDone;
	logic [15:0] fwCmd;
	logic        clearBusy;
	logic        irqOut;
	logic [31:0] rdv;
	int          mismatches;
	int          n_compared;
	rxie_rx_interrupt_status_enable i_rxie_rx_interrupt_status_enable (.clk, .arst_n, .regAddr,
		.regWData, .regWr, .regRd, .regRData, .evtSet, .sleepActive, .fwCmdDone, .fwCmd,
		.clearBusy, .irqOut);
	rxie_host_model i_rxie_host_model (.clk, .regAddr, .regWData, .regWr, .regRd, .regRData);
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		i_rxie_host_model.rd(a, rdv);
		chk(rdv, exp);
	endtask
	task automatic pulse(input logic [31:0] v);
		@(posedge clk) evtSet <= v;
		@(posedge clk) evtSet <= 32'h0;
	endtask
	task automatic t_access;
		rd(16'h0034, 32'hF67FFFFF);
		rd(16'h0030, 32'h0);
		chk({31'h0, irqOut}, 32'h0);
		i_rxie_host_model.wr(16'h0034, 32'h0);
		rd(16'h0034, 32'h000C0000);
		i_rxie_host_model.wr(16'h0034, 32'hFFFFFFFF);
		rd(16'h0034, 32'hF67FFFFF);
		i_rxie_host_model.wr(16'h0030, 32'hFFFFFFFF);
		rd(16'h0030, 32'h0);
		rd(16'h0038, 32'h0);
		$display("test access done");
	endtask
	task automatic t_events;
		logic [31:0] e;
		e = 32'h0;
		for (int i = 0; i < 14; i++) begin
			pulse(32'h1 << i);
			e[i] = 1'b1;
			rd(16'h0030, e);
			chk({31'h0, irqOut}, 32'h1);
		end
		i_rxie_host_model.clear_irq;
		rd(16'h0030, 32'h0);
		chk({31'h0, irqOut}, 32'h0);
		$display("test events done");
	endtask
	task automatic t_block;
		i_rxie_host_model.wr(16'h0034, 32'h0);
		pulse(32'h4);
		rd(16'h0030, 32'h4);
		chk({31'h0, irqOut}, 32'h0);
		i_rxie_host_model.wr(16'h0034, 32'h4);
		repeat (2) @(posedge clk);
		#1 chk({31'h0, irqOut}, 32'h1);
		i_rxie_host_model.clear_irq;
		i_rxie_host_model.wr(16'h0034, 32'hFFFFFFFF);
		$display("test block done");
	endtask
	task automatic t_sleep;
		@(posedge clk) sleepActive <= 1'b1;
		rd(16'h0030, 32'h4000);
		chk({31'h0, irqOut}, 32'h1);
		i_rxie_host_model.clear_irq;
		rd(16'h0030, 32'h4000);
		@(posedge clk) sleepActive <= 1'b0;
		rd(16'h0030, 32'h0);
		$display("test sleep done");
	endtask
	task automatic t_cmd;
		i_rxie_host_model.wr(16'h004E, 32'h0090);
		rd(16'h004E, 32'h0090);
		chk({16'h0, fwCmd}, 32'h0090);
		@(posedge clk) fwCmdDone <= 16'h0010;
		@(posedge clk) fwCmdDone <= 16'h0;
		rd(16'h004E, 32'h0080);
		pulse(32'h8);
		rd(16'h004E, 32'h0);
		rd(16'h0030, 32'h8);
		// Every command bit at once; the clear sequence runs beside the others
		i_rxie_host_model.wr(16'h004E, 32'h0000FFFF);
		rd(16'h004E, 32'h83B0);
		chk({31'h0, clearBusy}, 32'h1);
		@(posedge clk) fwCmdDone <= 16'hFFFF;
		@(posedge clk) fwCmdDone <= 16'h0;
		rd(16'h004E, 32'h0);
		chk({31'h0, clearBusy}, 32'h0);
		rd(16'h0030, 32'h0);
		// All sources at once: upper flags latch, reserved and level bits do not
		pulse(32'hFFFFFFFF);
		rd(16'h0030, 32'hF67FBFFF);
		chk({31'h0, irqOut}, 32'h1);
		i_rxie_host_model.clear_irq;
		rd(16'h0030, 32'h0);
		chk({31'h0, irqOut}, 32'h0);
		$display("test command done");
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		arst_n = 1'b0;
		evtSet = 32'h0;
		sleepActive = 1'b0;
		fwCmdDone = 16'h0;
		mismatches = 0;
		n_compared = 0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		t_access;
		t_events;
		t_block;
		t_sleep;
		t_cmd;
		conclude;
	end
	// Hang guard
	initial begin
		#200000;
		mismatches++;
		conclude;
	end
endmodule
bind rxie_rx_interrupt_status_enable rxie_ise_asserts i_rxie_ise_asserts (.clk, .arst_n, .regAddr,
	.regWData, .regWr, .regRd, .regRData, .evtSet, .sleepActive, .fwCmdDone, .fwCmd,
	.clearBusy, .irqOut);
